/* verilog/wdw_defines.svh */
// Constants for the windowed watchdog
`ifndef WDW_DEFINES_SVH
`define WDW_DEFINES_SVH
`define WDW_CNT_W 14
`define WDW_PRE_W 7
`define WDW_INIT_00 14'h03ff
`define WDW_INIT_01 14'h0fff
`define WDW_INIT_10 14'h1fff
`define WDW_INIT_11 14'h3fff
`define WDW_DIV_16 7'h0f
`define WDW_DIV_128 7'h7f
`define WDW_DIV_2 7'h01
`define WDW_REFRESH_FIRST 8'h00
`define WDW_REFRESH_SECOND 8'hff
`endif

/* verilog/wdw_pkg.sv */
// Types for the windowed watchdog
package wdw_pkg;
   typedef enum logic [2:0] {
      WDW_IDLE = 3'b001,
      WDW_RUN = 3'b010,
      WDW_ARMED = 3'b100
   } wdw_state_t;
   typedef struct packed {
      logic [1:0] underflow_period_sel;
      logic [1:0] ack_window_sel;
      logic start_select_option;
   } wdw_option_t;
endpackage

/* verilog/wdw_watchdog.sv */
// Windowed watchdog timer clocked from the CPU clock
`timescale 1ns/10ps
`include "wdw_defines.svh"
module wdw_watchdog #(
   parameter int CNT_W = `WDW_CNT_W
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire wdw_pkg::wdw_option_t option_byte,
   input wire logic refresh_wr,
   input wire logic [7:0] refresh_wdata,
   input wire logic start_wr,
   input wire logic prescaler_select,
   input wire logic low_speed_clock_select,
   input wire logic underflow_action_select,
   input wire logic wait_mode,
   input wire logic stop_mode,
   output logic wdt_irq,
   output logic wdt_reset,
   output logic running,
   output logic [CNT_W-1:0] count_value
);
   // =====================================================
   // Decoding
   // =====================================================
   function automatic logic [CNT_W-1:0] init_count(input logic [1:0] sel);
      case (sel)
         2'h0: init_count = `WDW_INIT_00;
         2'h1: init_count = `WDW_INIT_01;
         2'h2: init_count = `WDW_INIT_10;
         default: init_count = `WDW_INIT_11;
      endcase
   endfunction

   wdw_pkg::wdw_state_t state_ff;
   wdw_pkg::wdw_state_t nxt_state;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic [`WDW_PRE_W-1:0] pre_ff;
   logic [`WDW_PRE_W-1:0] nxt_pre;
   logic first_seen_ff;
   logic nxt_first_seen;
   logic irq_ff;
   logic rst_ff;
   logic init_pending_ff;
   logic running_ff;

   wire [CNT_W-1:0] reload_val = init_count(option_byte.underflow_period_sel);
   wire [`WDW_PRE_W-1:0] div_top = low_speed_clock_select ? `WDW_DIV_2 :
      (prescaler_select ? `WDW_DIV_128 : `WDW_DIV_16);
   wire is_counting = (state_ff != wdw_pkg::WDW_IDLE);
   wire paused = wait_mode | stop_mode;
   wire advance = is_counting & ~paused;
   wire tick = advance & (pre_ff >= div_top);
   wire underflow = tick & (cnt_ff == {CNT_W{1'b0}});
   // Window thresholds: remaining count at or below fraction of period
   wire [CNT_W-1:0] q1 = {2'b00, reload_val[CNT_W-1:2]};
   wire [CNT_W-1:0] q2 = {1'b0, reload_val[CNT_W-1:1]};
   wire [CNT_W-1:0] win_top = (option_byte.ack_window_sel == 2'h0) ? q1 :
      (option_byte.ack_window_sel == 2'h1) ? q2 :
      (option_byte.ack_window_sel == 2'h2) ? CNT_W'(q1 + q2) : reload_val;
   wire in_window = (cnt_ff <= win_top);
   wire wr_first = refresh_wr & (refresh_wdata == `WDW_REFRESH_FIRST);
   wire wr_second = refresh_wr & (refresh_wdata == `WDW_REFRESH_SECOND);
   wire refresh_seq = wr_second & first_seen_ff;
   wire refresh_ok = refresh_seq & in_window & is_counting;
   wire refresh_bad = refresh_seq & ~in_window & is_counting;
   wire fault = underflow | refresh_bad;

   // =====================================================
   // Next state
   // =====================================================
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         wdw_pkg::WDW_IDLE:
         begin
            if (start_wr)
            begin
               nxt_state = wdw_pkg::WDW_RUN;
            end
         end
         wdw_pkg::WDW_RUN: nxt_state = wdw_pkg::WDW_RUN;
         wdw_pkg::WDW_ARMED: nxt_state = wdw_pkg::WDW_RUN;
         default: nxt_state = wdw_pkg::WDW_IDLE;
      endcase
   end

   assign nxt_pre = advance ? ((pre_ff >= div_top) ? '0 : `WDW_PRE_W'(pre_ff + 1'b1)) :
      pre_ff;
   assign nxt_cnt = (init_pending_ff | refresh_seq | underflow) ? reload_val :
      (tick ? CNT_W'(cnt_ff - 1'b1) : cnt_ff);
   assign nxt_first_seen = refresh_wr ? wr_first : first_seen_ff;
   wire nxt_running = init_pending_ff ? ~option_byte.start_select_option :
      (nxt_state == wdw_pkg::WDW_RUN);

   // =====================================================
   // Registers
   // =====================================================
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_ff <= wdw_pkg::WDW_ARMED;
         init_pending_ff <= 1'b1;
      end
      else
      begin
         // Strap sampled after release
         if (init_pending_ff)
         begin
            state_ff <= option_byte.start_select_option ? wdw_pkg::WDW_IDLE :
               wdw_pkg::WDW_RUN;
         end
         else
         begin
            state_ff <= nxt_state;
         end
         init_pending_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_ff <= '0;
         pre_ff <= '0;
         first_seen_ff <= 1'b0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         pre_ff <= init_pending_ff ? '0 : nxt_pre;
         first_seen_ff <= nxt_first_seen;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         irq_ff <= 1'b0;
         rst_ff <= 1'b0;
      end
      else
      begin
         irq_ff <= fault & ~underflow_action_select;
         rst_ff <= fault & underflow_action_select;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         running_ff <= 1'b0;
      end
      else
      begin
         running_ff <= nxt_running;
      end
   end

   assign wdt_irq = irq_ff;
   assign wdt_reset = rst_ff;
   assign running = running_ff;
   assign count_value = cnt_ff;

   // =====================================================
   // Checks
   // =====================================================
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   // =====================================================
   // Fault outputs
   // =====================================================
   chk_underflow_irq: assert property (
      underflow && !underflow_action_select |=> wdt_irq && !wdt_reset)
      else $error("underflow did not raise interrupt");
   chk_underflow_rst: assert property (
      underflow && underflow_action_select |=> wdt_reset && !wdt_irq)
      else $error("underflow did not raise reset");
   chk_bad_refresh: assert property (
      refresh_bad && underflow_action_select |=> wdt_reset)
      else $error("bad refresh not punished");
   chk_bad_irq: assert property (
      refresh_bad && !underflow_action_select |=> wdt_irq && !wdt_reset)
      else $error("bad refresh raised no interrupt");
   chk_irq_cause: assert property (
      wdt_irq |-> $past(fault && !underflow_action_select))
      else $error("interrupt without a fault");
   chk_rst_cause: assert property (
      wdt_reset |-> $past(fault && underflow_action_select))
      else $error("reset without a fault");
   chk_fault_excl: assert property (
      !(wdt_irq && wdt_reset))
      else $error("interrupt and reset together");

   // =====================================================
   // Counting
   // =====================================================
   chk_tick_dec: assert property (
      tick && cnt_ff != 0 && !refresh_seq && !init_pending_ff |=> cnt_ff == $past(cnt_ff) - 1)
      else $error("count did not decrement");
   chk_cnt_hold: assert property (
      advance && !tick && !refresh_seq && !init_pending_ff |=> $stable(cnt_ff))
      else $error("count moved between ticks");
   chk_underflow_load: assert property (
      underflow |=> cnt_ff == $past(reload_val))
      else $error("underflow did not reload");
   chk_pause_hold: assert property (
      is_counting && paused && !refresh_seq && !init_pending_ff
      |=> $stable(cnt_ff) && $stable(pre_ff))
      else $error("count moved while paused");
   chk_pause_quiet: assert property (
      paused && !refresh_wr |=> !wdt_irq && !wdt_reset)
      else $error("fault while paused");
   chk_pre_wrap: assert property (
      advance && pre_ff == div_top |=> pre_ff == 0)
      else $error("prescaler wrap wrong");
   chk_pre_step: assert property (
      advance && pre_ff < div_top && !init_pending_ff |=> pre_ff == $past(pre_ff) + 1)
      else $error("prescaler did not step");
   chk_ls_tick: assert property (
      advance && low_speed_clock_select && pre_ff == 0 && !init_pending_ff
      |=> tick || paused || !low_speed_clock_select)
      else $error("low-speed divide is not two");

   // =====================================================
   // Start and strap
   // =====================================================
   chk_idle_hold: assert property (
      state_ff == wdw_pkg::WDW_IDLE && !start_wr |=> state_ff == wdw_pkg::WDW_IDLE)
      else $error("left idle without start");
   chk_start_run: assert property (
      state_ff == wdw_pkg::WDW_IDLE && start_wr |=> running)
      else $error("start write did not start");
   chk_strap_stop: assert property (
      init_pending_ff && option_byte.start_select_option |=> !running && !is_counting)
      else $error("counting without start write");
   chk_strap_run: assert property (
      init_pending_ff && !option_byte.start_select_option |=> running)
      else $error("no automatic start");
   chk_idle_quiet: assert property (
      !is_counting && !refresh_seq |=> $stable(cnt_ff) && $stable(pre_ff))
      else $error("count moved while stopped");
   chk_idle_no_fault: assert property (
      !is_counting |=> !wdt_irq && !wdt_reset)
      else $error("fault while stopped");
   chk_running_flag: assert property (
      running == (state_ff == wdw_pkg::WDW_RUN))
      else $error("running flag out of step");

   // =====================================================
   // Refresh
   // =====================================================
   chk_good_refresh: assert property (
      refresh_ok && !underflow
      |=> !wdt_irq && !wdt_reset && cnt_ff == $past(reload_val))
      else $error("good refresh misbehaved");
   chk_refresh_load: assert property (
      refresh_seq |=> cnt_ff == $past(reload_val))
      else $error("refresh did not reload");
   chk_refresh_pair: assert property (
      wr_second && !first_seen_ff && !tick && !init_pending_ff |=> cnt_ff == $past(cnt_ff))
      else $error("lone FFh reloaded");
   chk_first_mark: assert property (
      wr_first |=> first_seen_ff)
      else $error("00h write not remembered");
   chk_first_drop: assert property (
      refresh_wr && !wr_first |=> !first_seen_ff)
      else $error("00h memory not cleared");
   chk_full_window: assert property (
      option_byte.ack_window_sel == 2'h3 && refresh_seq |-> !refresh_bad)
      else $error("refresh refused in full window");
   chk_early_refresh: assert property (
      option_byte.ack_window_sel == 2'h0 && refresh_seq && is_counting &&
      {cnt_ff, 2'b00} > {2'b00, reload_val} + 16'h0004 |-> refresh_bad)
      else $error("early refresh accepted");

   cov_underflow: cover property (underflow);
   cov_good: cover property (refresh_ok);
   cov_bad: cover property (refresh_bad);
   cov_start: cover property (state_ff == wdw_pkg::WDW_IDLE && start_wr);
endmodule

/* dv/wdw_cpu_model.sv */
// CPU-side model issuing refresh and start writes
`timescale 1ns/10ps
module wdw_cpu_model (
   input wire logic ref_clk,
   output logic refresh_wr,
   output logic [7:0] refresh_wdata,
   output logic start_wr
);
   initial
   begin
      refresh_wr = 1'b0;
      refresh_wdata = 8'h5a;
      start_wr = 1'b0;
   end
   // Two back-to-back writes, used only while counting
   task automatic wr2(input logic [7:0] a, input logic [7:0] b);
      @(posedge ref_clk);
      #1;
      refresh_wr = 1'b1;
      refresh_wdata = a;
      @(posedge ref_clk);
      #1;
      refresh_wdata = b;
      @(posedge ref_clk);
      #1;
      refresh_wr = 1'b0;
      refresh_wdata = ~b;
   endtask
   task automatic start;
      @(posedge ref_clk);
      #1;
      start_wr = 1'b1;
      @(posedge ref_clk);
      #1;
      start_wr = 1'b0;
   endtask
endmodule

/* dv/wdw_watchdog_bench.sv */
// Self-checking bench for the windowed watchdog
`timescale 1ns/10ps
module wdw_watchdog_bench;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   wdw_pkg::wdw_option_t opt = '0;
   logic ps = 1'b0, ls = 1'b1, act = 1'b0, wm = 1'b0, sm = 1'b0;
   logic rwr, swr, irq, rst, run;
   logic [7:0] rdat;
   logic [13:0] cnt, c0, thr;
   logic [13:0] init [4] = '{14'h03ff, 14'h0fff, 14'h1fff, 14'h3fff};
   int fails = 0, total_checks = 0, nirq = 0, nrst = 0, ei = 0, er = 0, n;
   always #2.5 ref_clk = ~ref_clk;
   wdw_cpu_model cpu (.ref_clk(ref_clk), .refresh_wr(rwr), .refresh_wdata(rdat), .start_wr(swr));
   wdw_watchdog uut (.ref_clk(ref_clk), .resetn(resetn), .option_byte(opt), .refresh_wr(rwr),
      .refresh_wdata(rdat), .start_wr(swr), .prescaler_select(ps), .low_speed_clock_select(ls),
      .underflow_action_select(act), .wait_mode(wm), .stop_mode(sm), .wdt_irq(irq),
      .wdt_reset(rst), .running(run), .count_value(cnt));
   always @(posedge ref_clk)
   begin
      nirq += (irq === 1'b1);
      nrst += (rst === 1'b1);
   end
   // ==========================================
   // Tasks
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e)
      begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic rst_dut(input wdw_pkg::wdw_option_t o);
      resetn = 1'b0;
      opt = o;
      cyc(10);
      resetn = 1'b1;
      cyc(2);
   endtask
   task automatic upto(input logic [13:0] v);
      for (int i = 0; i < 3000 && cnt > v; i++)
         cyc(1);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ==========================================
   // Tests
   initial
   begin
      for (int p = 0; p < 4; p++)
      begin
         rst_dut({p[1:0], 2'b11, 1'b0});
         chk(run, 1);
         chk(16'(init[p] - cnt < 14'h0002), 1);
      end
      $display("period codes done");
      for (int k = 0; k < 3; k++)
      begin
         ls = (k == 0);
         ps = (k == 2);
         n = 2 << (3 * k);
         cyc(n);
         c0 = cnt;
         cyc(4 * n);
         chk(c0 - cnt, 4);
      end
      ls = 1'b1;
      ps = 1'b0;
      $display("prescaler done");
      wm = 1'b1;
      c0 = cnt;
      cyc(40);
      chk(cnt, c0);
      wm = 1'b0;
      sm = 1'b1;
      cyc(40);
      chk(cnt, c0);
      sm = 1'b0;
      cyc(8);
      chk(c0 - cnt, 4);
      $display("pause done");
      for (int w = 0; w < 4; w++)
      begin
         act = w[0];
         rst_dut({2'b00, w[1:0], 1'b0});
         thr = 14'((32'h03ff * (w + 1)) / 4);
         cpu.wr2(8'h55, 8'hff);
         if (w < 3)
         begin
            upto(thr + 14'h0008);
            cpu.wr2(8'h00, 8'hff);
            ei += !act;
            er += act;
         end
         upto(thr - 14'h0008);
         cpu.wr2(8'h00, 8'hff);
         cyc(3);
         chk(nirq, ei);
         chk(nrst, er);
         chk(cnt > 14'h03f0, 1);
      end
      $display("window done");
      for (int a = 0; a < 2; a++)
      begin
         act = a[0];
         n = nirq + nrst;
         for (int i = 0; i < 2300 && nirq + nrst == n; i++)
            cyc(1);
         ei += !act;
         er += act;
         chk(nirq, ei);
         chk(nrst, er);
         chk(cnt > 14'h03fc, 1);
      end
      $display("underflow done");
      rst_dut(5'b00001);
      cyc(20);
      chk(run, 0);
      chk(cnt, 14'h03ff);
      cpu.start();
      cyc(2);
      chk(run, 1);
      $display("start select done");
      report_and_stop();
   end
   initial
   begin
      #200000;
      fails++;
      report_and_stop();
   end
endmodule
